// *** design/rwtu_core.sv ***
// Register window trap unit: detects spill, fill and dirty-window traps,
// picks the vector and moves the window pointer before handler entry.
// Assumes one core clock, synchronous reset; window counts come from core state.
// Function
// RQ1: Save with no free window raises spill
// RQ2: Restore with nothing restorable raises fill
// RQ3: Save with clean minus restorable zero: dirty
// RQ4: Spill wins over dirty-window on save
// RQ5: Vector select: two three-bit subfields
// RQ6: No foreign windows: current subfield picks vector
// RQ7: Foreign windows: foreign family, foreign subfield
// RQ8: Spill types 080-09F current, 0A0-0BF foreign
// RQ9: Window pointer wraps modulo window count
// RQ10: Save spill advances pointer by two
// RQ11: Flush spill advances by free count plus two
// RQ12: Flush windows may raise spill traps
// RQ13: Fill trap decrements pointer by one
// RQ14: Dirty trap increments pointer by one
// RQ15: Retry re-executes the trapped instruction
// RQ16: Subfield low bits index vector within family
module rwtu_core #(
  parameter int unsigned NWIN = 8,  // Implemented register windows
  parameter int unsigned CW = 3     // Window pointer width
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_save,               // Save instruction issues (pulse)
  input wire logic i_restore,            // Restore instruction issues (pulse)
  input wire logic i_flush,              // Flush windows instruction issues (pulse)
  input wire logic i_retry,              // Handler returns via retry (pulse)
  input wire logic [CW-1:0] i_free_save_window_count,
  input wire logic [CW-1:0] i_restorable_window_count,
  input wire logic [CW-1:0] i_clean_window_count,
  input wire logic [CW-1:0] i_foreign_window_count,
  input wire logic i_vsel_we,            // Write the vector select register
  input wire logic [5:0] i_vsel_wdata,   // Value written
  input wire logic i_cwp_we,             // Software write of window pointer
  input wire logic [CW-1:0] i_cwp_wdata,
  output logic [5:0] o_window_trap_vector_select,
  output logic [CW-1:0] o_current_window_pointer,
  output logic o_trap,                   // One-cycle trap entry pulse
  output logic [8:0] o_trap_type,        // Trap type of last trap
  output logic [1:0] o_trap_kind,        // Kind of last trap
  output logic o_in_handler,             // Handler running, issue blocked
  output logic o_replay,                 // One-cycle pulse: re-issue trapped instr
  output logic [1:0] o_replay_op         // 0 save, 1 restore, 2 flush
);
  // Register state
  logic [5:0] vsel_q, vsel_d;
  logic [CW-1:0] cwp_q, cwp_d;
  logic trap_q, trap_d;
  logic [8:0] tt_q, tt_d;
  logic [1:0] kind_q, kind_d;
  rwtu_pkg::rwtu_state_t st_q, st_d;
  logic replay_q, replay_d;
  logic [1:0] op_q, op_d;            // Trapped instruction, kept for retry
  logic in_handler_q, in_handler_d;  // Registered handler flag for the output
  // Condition decode
  logic [CW-1:0] clean_avail;        // Clean windows usable by save
  logic ovf, unf, dirty;
  logic foreign;
  logic [2:0] vec_n;
  logic [CW:0] step;

  // Detection; a flush spills only when occupied windows remain
  always_comb begin
    clean_avail = i_clean_window_count - i_restorable_window_count; // RQ3
    foreign = (i_foreign_window_count != '0);
    ovf = (i_save && i_free_save_window_count == '0) // RQ1
       || (i_flush && (i_restorable_window_count != '0 || foreign)); // RQ12
    unf = i_restore && i_restorable_window_count == '0; // RQ2
    dirty = i_save && !ovf && clean_avail == '0; // RQ3 RQ4
    vec_n = foreign ? vsel_q[rwtu_pkg::VSEL_OTHER_LSB +: rwtu_pkg::VSEL_W] // RQ7
                    : vsel_q[rwtu_pkg::VSEL_NORM_LSB +: rwtu_pkg::VSEL_W]; // RQ6 RQ16
  end

  // Next-state: trap entry, pointer update, retry path
  always_comb begin
    vsel_d = i_vsel_we ? i_vsel_wdata : vsel_q; // RQ5
    cwp_d = i_cwp_we ? i_cwp_wdata : cwp_q;
    trap_d = 1'b0;
    tt_d = tt_q;
    kind_d = kind_q;
    st_d = st_q;
    replay_d = 1'b0;
    op_d = op_q;
    step = '0;
    case (st_q)
      rwtu_pkg::RWTU_ST_RUN: begin
        if (ovf) begin
          // Save has zero free windows, so one formula covers both causes
          step = (CW+1)'(i_flush ? i_free_save_window_count : '0) + (CW+1)'(2); // RQ10 RQ11
          // Sum in int: pointer plus free count plus two can pass the pointer width
          cwp_d = CW'((int'(cwp_q) + int'(step)) % int'(NWIN)); // RQ9
          tt_d = (foreign ? rwtu_pkg::TT_SPILL_OTHER : rwtu_pkg::TT_SPILL_NORM)
               | (9'(vec_n) << rwtu_pkg::VEC_STEP_SHIFT); // RQ8
          kind_d = rwtu_pkg::RWTU_KIND_SPILL;
          op_d = i_flush ? 2'h2 : 2'h0;
          trap_d = 1'b1;
          st_d = rwtu_pkg::RWTU_ST_HANDLER;
        end else if (unf) begin
          cwp_d = (cwp_q == '0) ? CW'(NWIN - 1) : cwp_q - CW'(1); // RQ13 RQ9
          tt_d = (foreign ? rwtu_pkg::TT_FILL_OTHER : rwtu_pkg::TT_FILL_NORM)
               | (9'(vec_n) << rwtu_pkg::VEC_STEP_SHIFT); // RQ6 RQ7
          kind_d = rwtu_pkg::RWTU_KIND_FILL;
          op_d = 2'h1;
          trap_d = 1'b1;
          st_d = rwtu_pkg::RWTU_ST_HANDLER;
        end else if (dirty) begin
          cwp_d = (cwp_q == CW'(NWIN - 1)) ? '0 : cwp_q + CW'(1); // RQ14 RQ9
          tt_d = rwtu_pkg::TT_CLEAN;
          kind_d = rwtu_pkg::RWTU_KIND_CLEAN;
          op_d = 2'h0;
          trap_d = 1'b1;
          st_d = rwtu_pkg::RWTU_ST_HANDLER;
        end
      end
      rwtu_pkg::RWTU_ST_HANDLER: begin
        // Retry re-issues the same instruction against updated state
        if (i_retry) begin
          replay_d = 1'b1; // RQ15
          st_d = rwtu_pkg::RWTU_ST_RUN;
        end
      end
      default: st_d = rwtu_pkg::RWTU_ST_RUN;
    endcase
    // Flag follows the next state so the port needs no decode gate
    in_handler_d = (st_d == rwtu_pkg::RWTU_ST_HANDLER);
  end

  // Registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      vsel_q <= rwtu_pkg::VSEL_RESET;
      cwp_q <= CW'(rwtu_pkg::CWP_RESET);
      trap_q <= 1'b0;
      tt_q <= rwtu_pkg::TT_RESET;
      kind_q <= 2'(rwtu_pkg::RWTU_KIND_NONE);
      st_q <= rwtu_pkg::RWTU_ST_RUN;
      replay_q <= 1'b0;
      op_q <= 2'h0;
      in_handler_q <= 1'b0;
    end else begin
      vsel_q <= vsel_d;
      cwp_q <= cwp_d;
      trap_q <= trap_d;
      tt_q <= tt_d;
      kind_q <= kind_d;
      st_q <= st_d;
      replay_q <= replay_d;
      op_q <= op_d;
      in_handler_q <= in_handler_d;
    end
  end

  // Every port is driven straight from a flip-flop
  assign o_window_trap_vector_select = vsel_q;
  assign o_current_window_pointer = cwp_q;
  assign o_trap = trap_q;
  assign o_trap_type = tt_q;
  assign o_trap_kind = kind_q;
  assign o_in_handler = in_handler_q;
  assign o_replay = replay_q;
  assign o_replay_op = op_q;

  // Checks
  spill_save_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ1
    st_q == rwtu_pkg::RWTU_ST_RUN && i_save && i_free_save_window_count == '0
    |=> o_trap && o_trap_kind == 2'(rwtu_pkg::RWTU_KIND_SPILL)) else $error("save overflow missed");
  fill_restore_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ2
    st_q == rwtu_pkg::RWTU_ST_RUN && i_restore && !i_save && !i_flush && i_restorable_window_count == '0
    |=> o_trap && o_trap_kind == 2'(rwtu_pkg::RWTU_KIND_FILL)) else $error("restore underflow missed");
  dirty_only_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ4
    st_q == rwtu_pkg::RWTU_ST_RUN && i_save && i_free_save_window_count == '0
    |=> o_trap_type != rwtu_pkg::TT_CLEAN) else $error("dirty raised with overflow");
  spill_range_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ8
    o_trap && o_trap_kind == 2'(rwtu_pkg::RWTU_KIND_SPILL)
    |-> o_trap_type >= 9'h080 && o_trap_type <= 9'h0BF) else $error("spill type out of range");
  spill_cwp_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ10
    st_q == rwtu_pkg::RWTU_ST_RUN && i_save && !i_flush && !i_cwp_we && i_free_save_window_count == '0
    |=> o_current_window_pointer == CW'(({1'b0, $past(cwp_q)} + 2) % NWIN)) else $error("spill pointer wrong");
  fill_cwp_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ13
    o_trap && o_trap_kind == 2'(rwtu_pkg::RWTU_KIND_FILL)
    |-> o_current_window_pointer == CW'(($past(cwp_q) + NWIN - 1) % NWIN)) else $error("fill pointer wrong");
  clean_cwp_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ14
    o_trap && o_trap_kind == 2'(rwtu_pkg::RWTU_KIND_CLEAN)
    |-> o_current_window_pointer == CW'(($past(cwp_q) + 1) % NWIN)) else $error("clean pointer wrong");
  retry_path_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ15
    o_in_handler && i_retry |=> o_replay && !o_in_handler) else $error("retry not replayed");
  // Compared in int: the window count cast to pointer width would wrap to zero
  cwp_wrap_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ9
    int'(o_current_window_pointer) < int'(NWIN)) else $error("pointer past window count");

  // Dirty-window and flush entry, foreign spill type
  dirty_save_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ3
    st_q == rwtu_pkg::RWTU_ST_RUN && i_save && i_free_save_window_count != '0
    && CW'(i_clean_window_count - i_restorable_window_count) == '0
    |=> o_trap && o_trap_kind == 2'(rwtu_pkg::RWTU_KIND_CLEAN)) else $error("dirty window missed");
  flush_spill_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ12
    st_q == rwtu_pkg::RWTU_ST_RUN && i_flush && i_restorable_window_count != '0
    |=> o_trap && o_trap_kind == 2'(rwtu_pkg::RWTU_KIND_SPILL)) else $error("flush spill missed");
  flush_cwp_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ11
    st_q == rwtu_pkg::RWTU_ST_RUN && i_flush && i_restorable_window_count != '0
    |=> int'(o_current_window_pointer)
        == (int'($past(cwp_q)) + int'($past(i_free_save_window_count)) + 2) % int'(NWIN)) else $error("flush pointer wrong");
  spill_other_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ8
    o_trap && o_trap_kind == 2'(rwtu_pkg::RWTU_KIND_SPILL) && $past(i_foreign_window_count) != '0
    |-> o_trap_type >= rwtu_pkg::TT_SPILL_OTHER && o_trap_type <= 9'h0BF) else $error("foreign spill type wrong");

  // Vector index within the chosen family, against the subfield held at issue
  normal_vec_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ6 RQ16
    o_trap && o_trap_kind != 2'(rwtu_pkg::RWTU_KIND_CLEAN) && $past(i_foreign_window_count) == '0
    |-> ((o_trap_type >> rwtu_pkg::VEC_STEP_SHIFT) & 9'h007)
        == 9'(($past(vsel_q) >> rwtu_pkg::VSEL_NORM_LSB) & 6'h07)) else $error("current vector wrong");
  foreign_vec_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ7 RQ16
    o_trap && o_trap_kind != 2'(rwtu_pkg::RWTU_KIND_CLEAN) && $past(i_foreign_window_count) != '0
    |-> ((o_trap_type >> rwtu_pkg::VEC_STEP_SHIFT) & 9'h007)
        == 9'(($past(vsel_q) >> rwtu_pkg::VSEL_OTHER_LSB) & 6'h07)) else $error("foreign vector wrong");

  // Handler refusal and retry bookkeeping
  handler_block_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ15
    o_in_handler && (i_save || i_restore || i_flush) |=> !o_trap) else $error("issue taken in handler");
  replay_fill_a: assert property (@(posedge i_clk) disable iff (i_srst) // RQ15
    o_trap && o_trap_kind == 2'(rwtu_pkg::RWTU_KIND_FILL) |-> o_replay_op == 2'h1) else $error("retry op not kept");
endmodule // rwtu_core

// *** design/rwtu_pkg.sv ***
// Package for the register window trap unit: widths, trap type bases, state codes.
// Assumes a single core clock and a synchronous active-high core reset.
package rwtu_pkg;
  localparam int unsigned VSEL_W = 3;             // Width of each vector select subfield
  localparam int unsigned VSEL_NORM_LSB = 0;      // Current-space subfield position
  localparam int unsigned VSEL_OTHER_LSB = 3;     // Foreign-space subfield position
  localparam logic [5:0] VSEL_RESET = 6'h00;      // Vector select reset value
  localparam logic [8:0] TT_SPILL_NORM = 9'h080;  // Spill, current space
  localparam logic [8:0] TT_SPILL_OTHER = 9'h0A0; // Spill, foreign space
  localparam logic [8:0] TT_FILL_NORM = 9'h0C0;   // Fill, current space
  localparam logic [8:0] TT_FILL_OTHER = 9'h0E0;  // Fill, foreign space
  localparam logic [8:0] TT_CLEAN = 9'h024;       // Dirty-window trap type
  localparam logic [8:0] TT_RESET = 9'h000;       // Trap type reset value
  localparam int unsigned VEC_STEP_SHIFT = 2;     // Vectors spaced four types apart
  localparam int unsigned CWP_RESET = 0;          // Window pointer reset value
  // Trap kinds reported with each trap, RWTU_KIND_NONE from reset
  typedef enum logic [1:0] {
    RWTU_KIND_SPILL,
    RWTU_KIND_FILL,
    RWTU_KIND_CLEAN,
    RWTU_KIND_NONE
  } rwtu_kind_t;
  // Unit state
  typedef enum logic [0:0] {
    RWTU_ST_RUN,
    RWTU_ST_HANDLER
  } rwtu_state_t;
endpackage : rwtu_pkg

// *** test/rwtu_core_tb.sv ***
// Bench for the window trap unit: issues save, restore and flush, checks traps and replay.
// Assumes rwtu_core with eight windows and a three-bit pointer, inputs driven on the falling edge.
module rwtu_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic sv = 1'b0, rs = 1'b0, fl = 1'b0, rt = 1'b0, vwe = 1'b0, cwe = 1'b0; // Pulses
  logic [2:0] fr = 3'h0, rc = 3'h0, cl = 3'h0, fw = 3'h0, cwd = 3'h0; // Count levels and pointer write data
  logic [5:0] vwd = 6'h00; // Vector select write data
  logic [5:0] vsel;
  logic [2:0] current_window_pointer;
  logic trap, inh, rep;
  logic [8:0] ttype;
  logic [1:0] kind, rop;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // 40 MHz core clock
  always #12.5 i_clk = ~i_clk;
  rwtu_core #(.NWIN(8), .CW(3)) DUT (.i_clk(i_clk), .i_srst(i_srst), .i_save(sv), .i_restore(rs),
    .i_flush(fl), .i_retry(rt), .i_free_save_window_count(fr), .i_restorable_window_count(rc),
    .i_clean_window_count(cl), .i_foreign_window_count(fw), .i_vsel_we(vwe), .i_vsel_wdata(vwd),
    .i_cwp_we(cwe), .i_cwp_wdata(cwd), .o_window_trap_vector_select(vsel), .o_current_window_pointer(current_window_pointer),
    .o_trap(trap), .o_trap_type(ttype), .o_trap_kind(kind), .o_in_handler(inh), .o_replay(rep),
    .o_replay_op(rop));
  // Closing report, reached from the main sequence or the cycle ceiling
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Value compare, narrow results zero-extended
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Preload vector select and pointer in one cycle
  task automatic setup(input logic [5:0] v, input logic [2:0] c);
    @(negedge i_clk);
    {vwe, vwd, cwe, cwd} = {1'b1, v, 1'b1, c};
    @(negedge i_clk);
    {vwe, cwe} = 2'h0;
  endtask
  // One-cycle instruction pulse {flush, restore, save} with its counts
  task automatic issue(input logic [2:0] op, input logic [2:0] f, r, c, o);
    @(negedge i_clk);
    {fl, rs, sv, fr, rc, cl, fw} = {op, f, r, c, o};
    @(negedge i_clk);
    {fl, rs, sv} = 3'h0;
  endtask
  // Trap entry fields, looked at in the pulse cycle
  task automatic trap_chk(input logic [1:0] k, input logic [8:0] t, input logic [2:0] c);
    chk({8'h00, trap}, 9'h001);
    chk({7'h00, kind}, {7'h00, k});
    chk(ttype, t);
    chk({6'h00, current_window_pointer}, {6'h00, c});
  endtask
  // Retry return, replay pulse carries the trapped op
  task automatic retry(input logic [1:0] op);
    @(negedge i_clk);
    rt = 1'b1;
    @(negedge i_clk);
    rt = 1'b0;
    chk({8'h00, rep}, 9'h001);
    chk({7'h00, rop}, {7'h00, op});
    @(negedge i_clk);
    chk({8'h00, inh}, 9'h000);
  endtask
  task automatic t_reset();
    chk({3'h0, vsel}, 9'h000);
    chk({6'h0, current_window_pointer}, 9'h000);
    chk({7'h0, kind}, 9'h003);
    chk({7'h0, trap, inh}, 9'h000);
    $display("reset test done");
  endtask
  task automatic t_spill();
    setup(6'h03, 3'h4);
    issue(3'h1, 3'h0, 3'h2, 3'h5, 3'h0);
    trap_chk(rwtu_pkg::RWTU_KIND_SPILL, 9'h08C, 3'h6);
    retry(2'h0);
    setup(6'h28, 3'h7);
    chk({3'h0, vsel}, 9'h028);
    issue(3'h1, 3'h0, 3'h2, 3'h5, 3'h1);
    trap_chk(rwtu_pkg::RWTU_KIND_SPILL, 9'h0B4, 3'h1);
    retry(2'h0);
    $display("spill test done");
  endtask
  task automatic t_fill();
    setup(6'h06, 3'h0);
    issue(3'h2, 3'h3, 3'h0, 3'h3, 3'h0);
    trap_chk(rwtu_pkg::RWTU_KIND_FILL, 9'h0D8, 3'h7);
    retry(2'h1);
    setup(6'h38, 3'h5);
    issue(3'h2, 3'h3, 3'h0, 3'h3, 3'h2);
    trap_chk(rwtu_pkg::RWTU_KIND_FILL, 9'h0FC, 3'h4);
    retry(2'h1);
    $display("fill test done");
  endtask
  task automatic t_dirty();
    setup(6'h00, 3'h2);
    issue(3'h1, 3'h1, 3'h1, 3'h5, 3'h0);
    chk({8'h00, trap}, 9'h000);
    issue(3'h1, 3'h2, 3'h3, 3'h3, 3'h0);
    trap_chk(rwtu_pkg::RWTU_KIND_CLEAN, rwtu_pkg::TT_CLEAN, 3'h3);
    issue(3'h2, 3'h2, 3'h0, 3'h3, 3'h0);
    chk({5'h00, trap, current_window_pointer}, 9'h003);
    retry(2'h0);
    issue(3'h1, 3'h0, 3'h3, 3'h3, 3'h0);
    trap_chk(rwtu_pkg::RWTU_KIND_SPILL, 9'h080, 3'h5);
    retry(2'h0);
    $display("dirty test done");
  endtask
  task automatic t_flush();
    setup(6'h02, 3'h1);
    issue(3'h4, 3'h3, 3'h1, 3'h4, 3'h0);
    trap_chk(rwtu_pkg::RWTU_KIND_SPILL, 9'h088, 3'h6);
    retry(2'h2);
    setup(6'h10, 3'h6);
    issue(3'h4, 3'h4, 3'h0, 3'h4, 3'h1);
    trap_chk(rwtu_pkg::RWTU_KIND_SPILL, 9'h0A8, 3'h4);
    retry(2'h2);
    issue(3'h4, 3'h7, 3'h0, 3'h7, 3'h0);
    chk({5'h00, trap, current_window_pointer}, 9'h004);
    $display("flush test done");
  endtask
  // Cycle ceiling, far above the roughly sixty cycles the tests need
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      end_of_test();
    end
  end
  // Main sequence: three reset cycles, then the scenarios
  initial begin
    repeat (3) @(negedge i_clk);
    i_srst = 1'b0;
    t_reset();
    t_spill();
    t_fill();
    t_dirty();
    t_flush();
    end_of_test();
  end
endmodule // rwtu_core_tb
